// ### design/gpio_port.sv
`timescale 1ns/1ps
// Overview of operation
// - direction bit 0 input, 1 output, reset input
// - drive stored data on outputs, read stored
// - direction register drives pad direction output
// - pad level readback, writes ignored
// - five interrupt types per bit
// - enable bit makes port bit interrupt source
// - output direction stops new, keeps pending
// - mask bit 1 blocks interrupt to controller
// - raw and masked status both readable
// - all interrupts ORed, no own mask
// - clear write drops pending edge interrupt
// - clear write ignores level interrupts
// - level interrupt holds while source active
// - debounce needs two clock edges stable
// - all inputs pass two sync flops, levels optionally a third
// - unused reads zero, never bus error
// - polarity bit selects low/falling or high/rising
// - dual edge overrides edge select, polarity
// - debounce enable routes input through debounce, except level input with level sync set
// - level sync bit synchronises level interrupts
module gpio_port
	import gpio_port_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [PORT_W-1:0] pwdata_i,
	output logic [PORT_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// pads
	input wire logic [PORT_W-1:0] pad_in_i,
	output logic [PORT_W-1:0] pad_out_o,
	output logic [PORT_W-1:0] pad_direction_out_o,
	// interrupt
	output logic irq_o
);
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		addr_hit = (a == off);
	endfunction : addr_hit

	// ****************************************
	// registers
	// ****************************************
	logic [PORT_W-1:0] port_out_data_r;
	logic [PORT_W-1:0] dir_r;
	logic [PORT_W-1:0] irq_en_r;
	logic [PORT_W-1:0] irq_mask_bits_r;
	logic [PORT_W-1:0] edge_sel_r;
	logic [PORT_W-1:0] pol_r;
	logic [PORT_W-1:0] deb_en_r;
	logic level_irq_sync_enable_r;
	logic [PORT_W-1:0] dual_edge_select_r;
	logic [PORT_W-1:0] edge_pend_r;
	logic [PORT_W-1:0] raw_r;
	logic [PORT_W-1:0] pad_s1_r;
	logic [PORT_W-1:0] pad_s2_r;
	logic [PORT_W-1:0] pad_s3_r;
	logic [PORT_W-1:0] deb_r;
	logic [PORT_W-1:0] edge_prev_r;
	logic [PORT_W-1:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic irq_r;

	// ****************************************
	// apb decode
	// ****************************************
	wire setup_ph = psel_i & ~penable_i;
	wire wr_en = psel_i & penable_i & pwrite_i & pready_r;
	wire wr_out_data = wr_en & addr_hit(paddr_i, OFF_OUT_DATA);
	wire wr_dir = wr_en & addr_hit(paddr_i, OFF_DIR);
	wire wr_irq_en = wr_en & addr_hit(paddr_i, OFF_IRQ_EN);
	wire wr_mask = wr_en & addr_hit(paddr_i, OFF_IRQ_MASK);
	wire wr_edge_sel = wr_en & addr_hit(paddr_i, OFF_IRQ_EDGE_SEL);
	wire wr_pol = wr_en & addr_hit(paddr_i, OFF_IRQ_POL);
	wire wr_deb = wr_en & addr_hit(paddr_i, OFF_DEB_EN);
	wire wr_clr = wr_en & addr_hit(paddr_i, OFF_EDGE_CLR);
	wire wr_lvl_sync = wr_en & addr_hit(paddr_i, OFF_LVL_SYNC);
	wire wr_dual = wr_en & addr_hit(paddr_i, OFF_DUAL_EDGE);
	// the write-only clear and every hole between offsets read back as zero
	wire rd_mapped =
		addr_hit(paddr_i, OFF_OUT_DATA) |
		addr_hit(paddr_i, OFF_DIR) |
		addr_hit(paddr_i, OFF_IRQ_EN) |
		addr_hit(paddr_i, OFF_IRQ_MASK) |
		addr_hit(paddr_i, OFF_IRQ_EDGE_SEL) |
		addr_hit(paddr_i, OFF_IRQ_POL) |
		addr_hit(paddr_i, OFF_MASKED_STAT) |
		addr_hit(paddr_i, OFF_RAW_STAT) |
		addr_hit(paddr_i, OFF_DEB_EN) |
		addr_hit(paddr_i, OFF_PAD_LEVEL) |
		addr_hit(paddr_i, OFF_LVL_SYNC) |
		addr_hit(paddr_i, OFF_DUAL_EDGE);
	wire rd_setup = setup_ph & ~pwrite_i;

	// ****************************************
	// interrupt detection
	// ****************************************
	// pads always pass two flops first; the level sync option adds a third
	wire [PORT_W-1:0] deb_src = (deb_r & deb_en_r) | (pad_s2_r & ~deb_en_r);
	wire [PORT_W-1:0] edge_src = deb_src;
	wire [PORT_W-1:0] lvl_src = level_irq_sync_enable_r ? pad_s3_r : deb_src;
	wire [PORT_W-1:0] active = irq_en_r & ~dir_r;
	wire [PORT_W-1:0] is_edge = edge_sel_r | dual_edge_select_r;
	wire [PORT_W-1:0] rise = edge_src & ~edge_prev_r;
	wire [PORT_W-1:0] fall = ~edge_src & edge_prev_r;
	wire [PORT_W-1:0] edge_evt = dual_edge_select_r & (rise | fall) | ~dual_edge_select_r
		& ((pol_r & rise) | (~pol_r & fall));
	wire [PORT_W-1:0] edge_hit = edge_evt & active & is_edge;
	wire [PORT_W-1:0] lvl_hit = active & ~is_edge & ~(lvl_src ^ pol_r);
	wire [PORT_W-1:0] clr_bits = wr_clr ? pwdata_i : RST_WORD;
	// a new edge beats a clear in the same cycle; disabling a bit drops its pending edge
	wire [PORT_W-1:0] edge_pend_nxt = ((edge_pend_r & ~clr_bits) | edge_hit) & irq_en_r;
	wire [PORT_W-1:0] raw_nxt = edge_pend_nxt | lvl_hit;
	wire [PORT_W-1:0] mask_nxt = wr_mask ? pwdata_i : irq_mask_bits_r;
	wire irq_nxt = |(raw_nxt & ~mask_nxt);
	wire [PORT_W-1:0] masked_stat = raw_r & ~irq_mask_bits_r;

	// ****************************************
	// read mux
	// ****************************************
	wire [PORT_W-1:0] rd_mux =
		addr_hit(paddr_i, OFF_OUT_DATA) ? port_out_data_r :
		addr_hit(paddr_i, OFF_DIR) ? dir_r :
		addr_hit(paddr_i, OFF_IRQ_EN) ? irq_en_r :
		addr_hit(paddr_i, OFF_IRQ_MASK) ? irq_mask_bits_r :
		addr_hit(paddr_i, OFF_IRQ_EDGE_SEL) ? edge_sel_r :
		addr_hit(paddr_i, OFF_IRQ_POL) ? pol_r :
		addr_hit(paddr_i, OFF_MASKED_STAT) ? masked_stat :
		addr_hit(paddr_i, OFF_RAW_STAT) ? raw_r :
		addr_hit(paddr_i, OFF_DEB_EN) ? deb_en_r :
		addr_hit(paddr_i, OFF_PAD_LEVEL) ? pad_s2_r :
		addr_hit(paddr_i, OFF_LVL_SYNC) ? {{(PORT_W-1){1'b0}}, level_irq_sync_enable_r} :
		addr_hit(paddr_i, OFF_DUAL_EDGE) ? dual_edge_select_r :
		RST_WORD;

	// ****************************************
	// bus flops
	// ****************************************
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_r <= RST_WORD;
			pready_r <= RST_BIT;
			pslverr_r <= RST_BIT;
		end else begin
			pready_r <= setup_ph;
			// error never raised; kept in a flop so every output is registered
			pslverr_r <= RST_BIT;
			prdata_r <= (setup_ph & ~pwrite_i) ? rd_mux : RST_WORD;
		end
	end

	// ****************************************
	// control registers
	// ****************************************
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			port_out_data_r <= RST_WORD;
			dir_r <= RST_WORD;
			irq_en_r <= RST_WORD;
			irq_mask_bits_r <= RST_WORD;
			edge_sel_r <= RST_WORD;
			pol_r <= RST_WORD;
			deb_en_r <= RST_WORD;
			level_irq_sync_enable_r <= RST_BIT;
			dual_edge_select_r <= RST_WORD;
		end else begin
			if (wr_out_data) port_out_data_r <= pwdata_i;
			if (wr_dir) dir_r <= pwdata_i;
			if (wr_irq_en) irq_en_r <= pwdata_i;
			irq_mask_bits_r <= mask_nxt;
			if (wr_edge_sel) edge_sel_r <= pwdata_i;
			if (wr_pol) pol_r <= pwdata_i;
			if (wr_deb) deb_en_r <= pwdata_i;
			if (wr_lvl_sync) level_irq_sync_enable_r <= pwdata_i[LVL_SYNC_BIT];
			if (wr_dual) dual_edge_select_r <= pwdata_i;
		end
	end

	// ****************************************
	// input path and interrupt state
	// ****************************************
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pad_s1_r <= RST_WORD;
			pad_s2_r <= RST_WORD;
			pad_s3_r <= RST_WORD;
			deb_r <= RST_WORD;
			edge_prev_r <= RST_WORD;
			edge_pend_r <= RST_WORD;
			raw_r <= RST_WORD;
			irq_r <= RST_BIT;
		end else begin
			pad_s1_r <= pad_in_i;
			pad_s2_r <= pad_s1_r;
			pad_s3_r <= pad_s2_r;
			deb_r <= (deb_r & ~(pad_s2_r ~^ pad_s3_r)) | (pad_s2_r & (pad_s2_r ~^ pad_s3_r));
			edge_prev_r <= edge_src;
			edge_pend_r <= edge_pend_nxt;
			raw_r <= raw_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign prdata_o = prdata_r;
	assign pready_o = pready_r;
	assign pslverr_o = pslverr_r;
	assign pad_out_o = port_out_data_r;
	assign pad_direction_out_o = dir_r;
	assign irq_o = irq_r;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_DIR_WRITE: assert property (wr_dir |=> pad_direction_out_o == $past(pwdata_i))
		else $error("direction output does not follow write");
	AST_DATA_READ: assert property (setup_ph && !pwrite_i && addr_hit(paddr_i, OFF_OUT_DATA)
		|=> prdata_o == pad_out_o)
		else $error("data readback differs from driven data");
	AST_PAD_READ: assert property (setup_ph && !pwrite_i && addr_hit(paddr_i, OFF_PAD_LEVEL)
		|=> prdata_o == $past(pad_s2_r))
		else $error("pad readback wrong");
	AST_PAD_NOWRITE: assert property (wr_en && addr_hit(paddr_i, OFF_PAD_LEVEL)
		|=> $stable(port_out_data_r) && $stable(dir_r) && $stable(irq_en_r))
		else $error("write to pad readback changed state");
	AST_OUT_NO_NEW: assert property (##1 1 |-> (raw_r & ~$past(raw_r) & $past(dir_r)) == RST_WORD)
		else $error("new interrupt on output bit");
	AST_IRQ_OR: assert property (irq_o == |(raw_r & ~irq_mask_bits_r))
		else $error("combined interrupt mismatch");
	AST_CLEAR: assert property (wr_clr && (edge_hit & pwdata_i) == RST_WORD
		|=> (edge_pend_r & $past(pwdata_i)) == RST_WORD)
		else $error("edge clear did not clear");
	AST_LEVEL_HOLD: assert property (lvl_hit != RST_WORD
		|=> (raw_r & $past(lvl_hit)) == $past(lvl_hit))
		else $error("level interrupt dropped while source active");
	AST_SET_WINS: assert property (wr_clr && (edge_hit & pwdata_i) != RST_WORD
		|=> (raw_r & $past(edge_hit)) == $past(edge_hit))
		else $error("edge lost against same-cycle clear");
	AST_DEB_STABLE: assert property ($changed(deb_r)
		|-> ((deb_r ^ $past(deb_r)) & ~$past(pad_s2_r ~^ pad_s3_r)) == RST_WORD)
		else $error("debounce moved on an unstable input");
	AST_NO_ERR: assert property (pready_o |-> !pslverr_o)
		else $error("bus error signalled");

	// ****************************************
	// bus protocol checks
	// ****************************************
	AST_READY_PULSE: assert property (setup_ph |=> pready_o)
		else $error("access phase not acknowledged");
	AST_READY_CAUSE: assert property (pready_o |-> $past(setup_ph))
		else $error("ready without setup phase");
	AST_RDATA_IDLE: assert property (!pready_o |-> prdata_o == RST_WORD)
		else $error("read data not zero outside access");
	AST_UNUSED_ZERO: assert property (rd_setup && !rd_mapped |=> prdata_o == RST_WORD)
		else $error("unused location read not zero");
	AST_SYNC_UPPER: assert property (rd_setup && addr_hit(paddr_i, OFF_LVL_SYNC)
		|=> prdata_o[PORT_W-1:1] == '0)
		else $error("unused sync bits read not zero");
	AST_RAW_READ: assert property (rd_setup && addr_hit(paddr_i, OFF_RAW_STAT)
		|=> prdata_o == $past(raw_r))
		else $error("raw status readback wrong");
	AST_MASKED_READ: assert property (rd_setup && addr_hit(paddr_i, OFF_MASKED_STAT)
		|=> prdata_o == $past(raw_r & ~irq_mask_bits_r))
		else $error("masked status readback wrong");

	// ****************************************
	// register write checks
	// ****************************************
	AST_DATA_WRITE: assert property (wr_out_data |=> pad_out_o == $past(pwdata_i))
		else $error("output data does not follow write");
	AST_EN_WRITE: assert property (wr_irq_en |=> irq_en_r == $past(pwdata_i))
		else $error("enable register does not follow write");
	AST_MASK_WRITE: assert property (wr_mask |=> irq_mask_bits_r == $past(pwdata_i))
		else $error("mask register does not follow write");
	AST_SEL_WRITE: assert property (wr_edge_sel |=> edge_sel_r == $past(pwdata_i))
		else $error("edge select does not follow write");
	AST_POL_WRITE: assert property (wr_pol |=> pol_r == $past(pwdata_i))
		else $error("polarity does not follow write");
	AST_DEB_WRITE: assert property (wr_deb |=> deb_en_r == $past(pwdata_i))
		else $error("debounce enable does not follow write");
	AST_DUAL_WRITE: assert property (wr_dual |=> dual_edge_select_r == $past(pwdata_i))
		else $error("dual edge select does not follow write");

	// ****************************************
	// interrupt behaviour checks
	// ****************************************
	// expected edge events spelled out per edge type, so a broken edge type decode shows up here
	wire [PORT_W-1:0] exp_rise = active & edge_sel_r & ~dual_edge_select_r & pol_r & rise;
	wire [PORT_W-1:0] exp_fall = active & edge_sel_r & ~dual_edge_select_r & ~pol_r & fall;
	wire [PORT_W-1:0] exp_dual = active & dual_edge_select_r & (rise | fall);
	wire [PORT_W-1:0] wrong_sense = active & edge_sel_r & ~dual_edge_select_r & ~pol_r & rise & ~edge_pend_r;

	AST_EDGE_RISE: assert property (exp_rise != RST_WORD
		|=> (raw_r & $past(exp_rise)) == $past(exp_rise))
		else $error("rising edge not captured");
	AST_EDGE_FALL: assert property (exp_fall != RST_WORD
		|=> (raw_r & $past(exp_fall)) == $past(exp_fall))
		else $error("falling edge not captured");
	AST_EDGE_DUAL: assert property (exp_dual != RST_WORD
		|=> (raw_r & $past(exp_dual)) == $past(exp_dual))
		else $error("dual edge not captured");
	AST_WRONG_SENSE: assert property (wrong_sense != RST_WORD
		|=> (edge_pend_r & $past(wrong_sense)) == RST_WORD)
		else $error("edge of wrong sense captured");
	AST_DISABLED_NO_RAW: assert property (##1 1 |-> (raw_r & ~$past(irq_en_r)) == RST_WORD)
		else $error("interrupt on disabled bit");
	AST_PEND_KEPT: assert property (wr_dir
		|=> (edge_pend_r & $past(edge_pend_r & irq_en_r)) == $past(edge_pend_r & irq_en_r))
		else $error("pending edge lost on direction change");
	AST_CLR_LEVEL: assert property (wr_clr
		|=> (raw_r & $past(lvl_hit)) == $past(lvl_hit))
		else $error("clear dropped a level interrupt");
	AST_ALL_MASKED: assert property (&irq_mask_bits_r |-> !irq_o)
		else $error("interrupt out with all bits masked");
	AST_IRQ_SOURCE: assert property (irq_o |-> raw_r != RST_WORD)
		else $error("interrupt out without a source");
	AST_DEB_FOLLOW: assert property (##1 1
		|-> ((deb_r ^ $past(pad_s2_r)) & $past(pad_s2_r ~^ pad_s3_r)) == RST_WORD)
		else $error("debounce did not take a stable input");
	AST_SYNC_STAGE: assert property (##1 1 |-> pad_s3_r == $past(pad_s2_r))
		else $error("level sync stage does not follow");

	COV_EDGE_IRQ: cover property (edge_hit != RST_WORD ##1 irq_o);
	COV_LEVEL_IRQ: cover property (lvl_hit != RST_WORD ##1 irq_o);
	COV_CLEAR: cover property (irq_o ##1 wr_clr ##1 !irq_o);
	COV_MASKED: cover property (raw_r != RST_WORD && !irq_o);
	COV_DEBOUNCE: cover property ((deb_en_r != RST_WORD) && $changed(deb_r));
endmodule : gpio_port

// ### design/gpio_port_pkg.sv
package gpio_port_pkg;
	// ****************************************
	// widths
	// ****************************************
	localparam int PORT_W = 32;
	localparam int ADDR_W = 12;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [ADDR_W-1:0] OFF_OUT_DATA = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_DIR = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 12'h030;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h034;
	localparam logic [ADDR_W-1:0] OFF_IRQ_EDGE_SEL = 12'h038;
	localparam logic [ADDR_W-1:0] OFF_IRQ_POL = 12'h03C;
	localparam logic [ADDR_W-1:0] OFF_MASKED_STAT = 12'h040;
	localparam logic [ADDR_W-1:0] OFF_RAW_STAT = 12'h044;
	localparam logic [ADDR_W-1:0] OFF_DEB_EN = 12'h048;
	localparam logic [ADDR_W-1:0] OFF_EDGE_CLR = 12'h04C;
	localparam logic [ADDR_W-1:0] OFF_PAD_LEVEL = 12'h050;
	localparam logic [ADDR_W-1:0] OFF_LVL_SYNC = 12'h060;
	localparam logic [ADDR_W-1:0] OFF_DUAL_EDGE = 12'h068;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [PORT_W-1:0] RST_WORD = 32'h0000_0000;
	localparam logic RST_BIT = 1'b0;
	localparam int LVL_SYNC_BIT = 0;
endpackage : gpio_port_pkg

// ### dv/gpio_pad_model.sv
`timescale 1ns/1ps
// ****************************************
// pad model: outputs win where enabled
// ****************************************
module gpio_pad_model
	import gpio_port_pkg::*;
(
	// pad side
	input wire logic [PORT_W-1:0] ext_i,
	input wire logic [PORT_W-1:0] dir_i,
	input wire logic [PORT_W-1:0] out_i,
	output logic [PORT_W-1:0] pad_o
);
	// a pad driven by the port shows the port's value, not the outside one
	assign pad_o = (dir_i & out_i) | (~dir_i & ext_i);
endmodule : gpio_pad_model

// ### dv/tb_gpio_port.sv
`timescale 1ns/1ps
module tb_gpio_port;
	import gpio_port_pkg::*;
	// ****************************************
	// signals and design
	// ****************************************
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [ADDR_W-1:0] paddr_i = '0;
	logic [PORT_W-1:0] pwdata_i = '0;
	logic [PORT_W-1:0] ext = '0;
	logic [PORT_W-1:0] pad_in, prdata_o, pad_out_o, pad_direction_out_o, rd, seed, d, dr;
	logic pready_o, pslverr_o, irq_o;
	int error_cnt = 0;
	int tests_run = 0;
	logic [ADDR_W-1:0] regs [13] = '{OFF_OUT_DATA, OFF_DIR, OFF_IRQ_EN, OFF_IRQ_MASK, OFF_IRQ_EDGE_SEL,
		OFF_IRQ_POL, OFF_MASKED_STAT, OFF_RAW_STAT, OFF_DEB_EN, OFF_EDGE_CLR, OFF_PAD_LEVEL, OFF_LVL_SYNC,
		OFF_DUAL_EDGE};
	always #4 core_clk_i = ~core_clk_i;
	gpio_port u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .pad_in_i(pad_in), .pad_out_o(pad_out_o),
		.pad_direction_out_o(pad_direction_out_o), .irq_o(irq_o));
	gpio_pad_model u_pad (.ext_i(ext), .dir_i(pad_direction_out_o), .out_i(pad_out_o), .pad_o(pad_in));
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
	endfunction : lfsr_next
	function automatic logic [31:0] exp_pad(input logic [31:0] dir, input logic [31:0] o, input logic [31:0] e);
		return (dir & o) | (~dir & e);
	endfunction : exp_pad
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk
	// full-word transfers only, setup then access, held until ready
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
		int n;
		@(posedge core_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		n = 0;
		@(negedge core_clk_i);
		while (pready_o !== 1'b1 && n < 8) begin
			n++;
			@(negedge core_clk_i);
		end
		rd = prdata_o;
		chk(32'h1, {31'h0, pready_o});
		chk(32'h0, {31'h0, pslverr_o});
		@(posedge core_clk_i);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(exp, rd);
	endtask : rc
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	// ****************************************
	// sequence
	// ****************************************
	initial begin
		repeat (20000) @(posedge core_clk_i);
		error_cnt++;
		print_verdict();
	end
	initial begin
		seed = 32'h4C950C84;
		repeat (16) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		foreach (regs[i]) rc(regs[i], RST_WORD);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr_next(seed);
			d = seed;
			seed = lfsr_next(seed);
			dr = seed;
			apb(1'b1, OFF_OUT_DATA, d);
			apb(1'b1, OFF_DIR, dr);
			ext <= lfsr_next(seed);
			rc(OFF_OUT_DATA, d);
			chk(d, pad_out_o);
			chk(dr, pad_direction_out_o);
			apb(1'b1, OFF_PAD_LEVEL, ~d);
			rc(OFF_PAD_LEVEL, exp_pad(dr, d, lfsr_next(seed)));
		end
		rc(12'h100, 32'h0);
		rc(12'h064, 32'h0);
		// interrupts: bit0 rising edge, bit1 high level, bit2 both edges
		ext <= 32'h0;
		apb(1'b1, OFF_DIR, 32'h0);
		apb(1'b1, OFF_OUT_DATA, 32'h0);
		apb(1'b1, OFF_IRQ_EDGE_SEL, 32'h5);
		apb(1'b1, OFF_IRQ_POL, 32'h3);
		apb(1'b1, OFF_DUAL_EDGE, 32'h4);
		apb(1'b1, OFF_IRQ_EN, 32'h7);
		ext <= 32'h1;
		repeat (6) @(posedge core_clk_i);
		chk(32'h1, {31'h0, irq_o});
		rc(OFF_RAW_STAT, 32'h1);
		apb(1'b1, OFF_IRQ_MASK, 32'h1);
		rc(OFF_MASKED_STAT, 32'h0);
		chk(32'h0, {31'h0, irq_o});
		rc(OFF_RAW_STAT, 32'h1);
		apb(1'b1, OFF_IRQ_MASK, 32'h0);
		apb(1'b1, OFF_EDGE_CLR, 32'h1);
		rc(OFF_RAW_STAT, 32'h0);
		ext <= 32'h3;
		repeat (6) @(posedge core_clk_i);
		apb(1'b1, OFF_EDGE_CLR, 32'h2);
		rc(OFF_MASKED_STAT, 32'h2);
		ext <= 32'h5;
		repeat (6) @(posedge core_clk_i);
		rc(OFF_RAW_STAT, 32'h4);
		apb(1'b1, OFF_EDGE_CLR, 32'h4);
		ext <= 32'h1;
		repeat (6) @(posedge core_clk_i);
		rc(OFF_RAW_STAT, 32'h4);
		apb(1'b1, OFF_EDGE_CLR, 32'h4);
		apb(1'b1, OFF_IRQ_POL, 32'h2);
		ext <= 32'h0;
		repeat (6) @(posedge core_clk_i);
		rc(OFF_RAW_STAT, 32'h1);
		apb(1'b1, OFF_DIR, 32'h1);
		rc(OFF_RAW_STAT, 32'h1);
		apb(1'b1, OFF_EDGE_CLR, 32'h1);
		apb(1'b1, OFF_OUT_DATA, 32'h1);
		apb(1'b1, OFF_OUT_DATA, 32'h0);
		repeat (6) @(posedge core_clk_i);
		rc(OFF_RAW_STAT, 32'h0);
		// debounce on bit0 rising: a one-cycle pulse must be dropped
		apb(1'b1, OFF_DIR, 32'h0);
		apb(1'b1, OFF_IRQ_POL, 32'h3);
		apb(1'b1, OFF_DEB_EN, 32'h1);
		rc(OFF_DEB_EN, 32'h1);
		ext <= 32'h1;
		@(posedge core_clk_i);
		ext <= 32'h0;
		repeat (8) @(posedge core_clk_i);
		rc(OFF_RAW_STAT, 32'h0);
		chk(32'h0, {31'h0, irq_o});
		ext <= 32'h1;
		repeat (8) @(posedge core_clk_i);
		rc(OFF_RAW_STAT, 32'h1);
		apb(1'b1, OFF_LVL_SYNC, 32'hFFFFFFFF);
		rc(OFF_LVL_SYNC, 32'h1);
		ext <= 32'h3;
		repeat (8) @(posedge core_clk_i);
		rc(OFF_RAW_STAT, 32'h3);
		chk(32'h1, {31'h0, irq_o});
		print_verdict();
	end
endmodule : tb_gpio_port
